// file: hdl/cor_consts.vh
/*
 * constants for the clock output routing and enable block: register
 * indexes, field positions, reset values and reserved-bit masks.
 * assumes it is included by bare name by the design files of the block.
 */
`ifndef COR_CONSTS_VH
`define COR_CONSTS_VH

// ----------------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define COR_IDX_GEN_EN 10'h24E
`define COR_IDX_FMT_EN 10'h250
`define COR_IDX_SRC_SEL 10'h251

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define COR_RST_GEN_EN 8'h00
`define COR_RST_FMT_EN 8'hF0
`define COR_RST_SRC_SEL 8'h00

// ----------------------------------------------------------------------
// writable-bit masks, reserved bits read as zero
// ----------------------------------------------------------------------
`define COR_MASK_GEN_EN 8'h03
`define COR_MASK_FMT_EN 8'hFF
`define COR_MASK_SRC_SEL 8'h0C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define COR_BIT_GEN_EN_0 0
`define COR_BIT_GEN_EN_1 1
`define COR_BIT_PAIR2_DIFF 7
`define COR_BIT_PAIR2_COPY 6
`define COR_BIT_PAIR0_DIFF 5
`define COR_BIT_PAIR0_COPY 4
`define COR_BIT_FAST_EN_3 3
`define COR_BIT_FAST_EN_2 2
`define COR_BIT_FAST_EN_1 1
`define COR_BIT_FAST_EN_0 0
`define COR_BIT_OUT3_SEL 3
`define COR_BIT_OUT2_SEL 2

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define COR_RESP_OKAY 2'b00
`define COR_RESP_SLVERR 2'b10

`endif

// file: hdl/cor_out_gate.v
/*
 * one clock output stage: registers the chosen source level, optionally
 * inverted for the minus leg of a pair, and its output enable.
 * assumes src is already synchronised to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module cor_out_gate (
   input wire clk_sys,
   input wire rst,
   input wire src,
   input wire inv,
   input wire en,
   output reg clk_out_ff,
   output reg oe_ff
);

   // ---------------------------------------------------------------
   // output stage
   // ---------------------------------------------------------------
   // a disabled output is held low so no runt edge leaks to the load
   always @(posedge clk_sys) begin
      if (rst) begin
         clk_out_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else begin
         clk_out_ff <= en & (src ^ inv);
         oe_ff <= en;
      end
   end

endmodule // cor_out_gate

`default_nettype wire

// file: hdl/cor_top.v
/*
 * clock output routing and enable: an axi4-lite register slave holding
 * three control registers, and the selection, format and enable logic of
 * two general cmos clock outputs and four fast clock outputs.
 * assumes the divider clocks arrive from outside the clk_sys domain and
 * are much slower than clk_sys; they are resampled, so each output
 * follows its source with three cycles of latency and clk_sys jitter.
 */
// The AXI4-Lite slave port was left to the implementer.
// Function
// - general out 0 is cmos from synth zero divider A, gated by its enable
// - general out 1 is cmos from synth zero divider B, gated by its enable
// - pair-2 type 1 makes outputs 2,3 differential from output-2 route
// - cmos pair 2: copy 0 gives own routes, copy 1 gives output-2 route
// - pair-0 type 1 makes outputs 0,1 differential from synth one A
// - cmos pair 0: copy 0 gives A and B, copy 1 gives A to both
// - output-3 enable gates output 3 in cmos, no effect in differential
// - output-2 enable gates output 2 in cmos, both in differential
// - output-1 enable gates output 1 in cmos, ignored in differential
// - output-0 enable gates output 0 in cmos, both in differential
// - output-3 route 0 picks synth one divider D, 1 picks divider B
// - output-2 route 0 picks synth one divider C, 1 picks divider A
`timescale 1ns/1ps
`default_nettype none
`include "cor_consts.vh"

module cor_top #(
   parameter ADDR_W = 12,
   parameter N_SRC = 6
) (
   input wire clk_sys,
   input wire rst,
   // axi4-lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // divider clocks of the two synthesizers
   input wire synthesizer_zero_div_a,
   input wire synthesizer_zero_div_b,
   input wire synthesizer_one_div_a,
   input wire synthesizer_one_div_b,
   input wire synthesizer_one_div_c,
   input wire synthesizer_one_div_d,
   // clock outputs and their drive enables
   output wire general_clock_out_0,
   output wire general_clock_out_0_oe,
   output wire general_clock_out_1,
   output wire general_clock_out_1_oe,
   output wire fast_clock_out_0,
   output wire fast_clock_out_0_oe,
   output wire fast_clock_out_1,
   output wire fast_clock_out_1_oe,
   output wire fast_clock_out_2,
   output wire fast_clock_out_2_oe,
   output wire fast_clock_out_3,
   output wire fast_clock_out_3_oe,
   // pair format, high while the pair drives as one differential output
   output reg pair0_differential_ff,
   output reg pair2_differential_ff
);

   // ---------------------------------------------------------------
   // source synchronisers
   // ---------------------------------------------------------------
   wire [N_SRC-1:0] src_raw;
   reg [N_SRC-1:0] src_meta_ff, src_sync_ff;

   assign src_raw = {synthesizer_one_div_d, synthesizer_one_div_c,
                     synthesizer_one_div_b, synthesizer_one_div_a,
                     synthesizer_zero_div_b, synthesizer_zero_div_a};

   // two flops per divider clock; only the second stage is read below
   always @(posedge clk_sys) begin
      if (rst) begin
         src_meta_ff <= {N_SRC{1'b0}};
         src_sync_ff <= {N_SRC{1'b0}};
      end else begin
         src_meta_ff <= src_raw;
         src_sync_ff <= src_meta_ff;
      end
   end

   wire s0_a = src_sync_ff[0];
   wire s0_b = src_sync_ff[1];
   wire s1_a = src_sync_ff[2];
   wire s1_b = src_sync_ff[3];
   wire s1_c = src_sync_ff[4];
   wire s1_d = src_sync_ff[5];

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   reg [7:0] general_output_enables_ff;
   reg [7:0] fast_output_format_enable_1_ff;
   reg [7:0] fast_output_source_select_1_ff;

   // ---------------------------------------------------------------
   // write channel
   // ---------------------------------------------------------------
   reg aw_held_ff, w_held_ff;
   reg [ADDR_W-1:0] aw_addr_ff;
   reg [7:0] w_byte_ff;
   reg w_lane0_ff;

   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire wr_go = aw_held_ff & w_held_ff & ~s_axi_bvalid;
   wire [9:0] wr_idx = aw_addr_ff[11:2];
   wire wr_hit_gen = (wr_idx == `COR_IDX_GEN_EN);
   wire wr_hit_fmt = (wr_idx == `COR_IDX_FMT_EN);
   wire wr_hit_src = (wr_idx == `COR_IDX_SRC_SEL);
   wire wr_hit = wr_hit_gen | wr_hit_fmt | wr_hit_src;

   // address and data are taken in either order and held until both are
   // in; ready stays low from the take until the response is accepted,
   // which keeps at most one write in flight
   always @(posedge clk_sys) begin
      if (rst) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         aw_addr_ff <= {ADDR_W{1'b0}};
         w_byte_ff <= 8'h00;
         w_lane0_ff <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `COR_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            w_held_ff <= 1'b1;
            w_byte_ff <= s_axi_wdata[7:0];
            w_lane0_ff <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `COR_RESP_OKAY : `COR_RESP_SLVERR;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // register update; only byte lane 0 carries data, reserved bits are
   // masked off so they can never be set
   always @(posedge clk_sys) begin
      if (rst) begin
         general_output_enables_ff <= `COR_RST_GEN_EN;
         fast_output_format_enable_1_ff <= `COR_RST_FMT_EN;
         fast_output_source_select_1_ff <= `COR_RST_SRC_SEL;
      end else if (wr_go & w_lane0_ff) begin
         if (wr_hit_gen) begin
            general_output_enables_ff <= w_byte_ff & `COR_MASK_GEN_EN;
         end else if (wr_hit_fmt) begin
            fast_output_format_enable_1_ff <= w_byte_ff & `COR_MASK_FMT_EN;
         end else if (wr_hit_src) begin
            fast_output_source_select_1_ff <= w_byte_ff & `COR_MASK_SRC_SEL;
         end
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire [9:0] rd_idx = s_axi_araddr[11:2];
   reg [7:0] rd_byte;
   reg rd_hit;

   // read decode; unmapped words answer zero with an error response
   always @* begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      if (rd_idx == `COR_IDX_GEN_EN) begin
         rd_byte = general_output_enables_ff;
      end else if (rd_idx == `COR_IDX_FMT_EN) begin
         rd_byte = fast_output_format_enable_1_ff;
      end else if (rd_idx == `COR_IDX_SRC_SEL) begin
         rd_byte = fast_output_source_select_1_ff;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // data is captured at the address take and held until rready
   always @(posedge clk_sys) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `COR_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= rd_hit ? `COR_RESP_OKAY : `COR_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // field decode
   // ---------------------------------------------------------------
   wire general_out_enable_0 = general_output_enables_ff[`COR_BIT_GEN_EN_0];
   wire general_out_enable_1 = general_output_enables_ff[`COR_BIT_GEN_EN_1];
   wire pair0_differential_select =
      fast_output_format_enable_1_ff[`COR_BIT_PAIR0_DIFF];
   wire pair2_differential_select =
      fast_output_format_enable_1_ff[`COR_BIT_PAIR2_DIFF];
   wire pair0_copy_source =
      fast_output_format_enable_1_ff[`COR_BIT_PAIR0_COPY];
   wire pair2_copy_source =
      fast_output_format_enable_1_ff[`COR_BIT_PAIR2_COPY];
   wire fast_out_enable_0 = fast_output_format_enable_1_ff[`COR_BIT_FAST_EN_0];
   wire fast_out_enable_1 = fast_output_format_enable_1_ff[`COR_BIT_FAST_EN_1];
   wire fast_out_enable_2 = fast_output_format_enable_1_ff[`COR_BIT_FAST_EN_2];
   wire fast_out_enable_3 = fast_output_format_enable_1_ff[`COR_BIT_FAST_EN_3];
   wire fast_out2_source_select =
      fast_output_source_select_1_ff[`COR_BIT_OUT2_SEL];
   wire fast_out3_source_select =
      fast_output_source_select_1_ff[`COR_BIT_OUT3_SEL];

   // ---------------------------------------------------------------
   // fast output routing
   // ---------------------------------------------------------------
   // the copy bit of pair 2 is not forced clear here when output 3 is
   // disabled; keeping the two consistent is left to software
   wire out2_src = fast_out2_source_select ? s1_a : s1_c;
   wire out3_own = fast_out3_source_select ? s1_b : s1_d;
   reg out1_src, out1_inv, out1_en;
   reg out3_src, out3_inv, out3_en;

   // pair 0: a differential pair drives the minus leg as the complement
   // of output 0 and takes the output-0 enable for both legs
   always @* begin
      if (pair0_differential_select) begin
         out1_src = s1_a;
         out1_inv = 1'b1;
         out1_en = fast_out_enable_0;
      end else begin
         out1_src = pair0_copy_source ? s1_a : s1_b;
         out1_inv = 1'b0;
         out1_en = fast_out_enable_1;
      end
   end

   // pair 2: same scheme, the pair source comes from the output-2 route
   always @* begin
      if (pair2_differential_select) begin
         out3_src = out2_src;
         out3_inv = 1'b1;
         out3_en = fast_out_enable_2;
      end else begin
         out3_src = pair2_copy_source ? out2_src : out3_own;
         out3_inv = 1'b0;
         out3_en = fast_out_enable_3;
      end
   end

   // format flags shown to the output pads
   always @(posedge clk_sys) begin
      if (rst) begin
         pair0_differential_ff <= 1'b0;
         pair2_differential_ff <= 1'b0;
      end else begin
         pair0_differential_ff <= pair0_differential_select;
         pair2_differential_ff <= pair2_differential_select;
      end
   end

   // ---------------------------------------------------------------
   // output stages
   // ---------------------------------------------------------------
   cor_out_gate u_gen0 (
      .clk_sys(clk_sys),
      .rst(rst),
      .src(s0_a),
      .inv(1'b0),
      .en(general_out_enable_0),
      .clk_out_ff(general_clock_out_0),
      .oe_ff(general_clock_out_0_oe)
   );

   cor_out_gate u_gen1 (
      .clk_sys(clk_sys),
      .rst(rst),
      .src(s0_b),
      .inv(1'b0),
      .en(general_out_enable_1),
      .clk_out_ff(general_clock_out_1),
      .oe_ff(general_clock_out_1_oe)
   );

   cor_out_gate u_fast0 (
      .clk_sys(clk_sys),
      .rst(rst),
      .src(s1_a),
      .inv(1'b0),
      .en(fast_out_enable_0),
      .clk_out_ff(fast_clock_out_0),
      .oe_ff(fast_clock_out_0_oe)
   );

   cor_out_gate u_fast1 (
      .clk_sys(clk_sys),
      .rst(rst),
      .src(out1_src),
      .inv(out1_inv),
      .en(out1_en),
      .clk_out_ff(fast_clock_out_1),
      .oe_ff(fast_clock_out_1_oe)
   );

   cor_out_gate u_fast2 (
      .clk_sys(clk_sys),
      .rst(rst),
      .src(out2_src),
      .inv(1'b0),
      .en(fast_out_enable_2),
      .clk_out_ff(fast_clock_out_2),
      .oe_ff(fast_clock_out_2_oe)
   );

   cor_out_gate u_fast3 (
      .clk_sys(clk_sys),
      .rst(rst),
      .src(out3_src),
      .inv(out3_inv),
      .en(out3_en),
      .clk_out_ff(fast_clock_out_3),
      .oe_ff(fast_clock_out_3_oe)
   );

endmodule // cor_top

`default_nettype wire

// file: dv/cor_monitor.sv
/*
 * cor_monitor: concurrent checks on the ports of cor_top.
 * assumes one clk_sys domain and a synchronous active-high rst.
 */
`timescale 1ns/1ps
`default_nettype none

module cor_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic synthesizer_zero_div_a,
   input wire logic synthesizer_zero_div_b,
   input wire logic synthesizer_one_div_a,
   input wire logic general_clock_out_0,
   input wire logic general_clock_out_0_oe,
   input wire logic general_clock_out_1,
   input wire logic general_clock_out_1_oe,
   input wire logic fast_clock_out_0,
   input wire logic fast_clock_out_0_oe,
   input wire logic fast_clock_out_1,
   input wire logic fast_clock_out_1_oe,
   input wire logic fast_clock_out_2,
   input wire logic fast_clock_out_2_oe,
   input wire logic fast_clock_out_3,
   input wire logic fast_clock_out_3_oe,
   input wire logic pair0_differential_ff,
   input wire logic pair2_differential_ff
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // enabled outputs trail their divider by two sync stages and a flop
   property p_gen0;
      general_clock_out_0_oe |->
         general_clock_out_0 == $past(synthesizer_zero_div_a, 3);
   endproperty
   a_gen0: assert property (p_gen0) else $error("gen out 0 source");
   property p_gen1;
      general_clock_out_1_oe |->
         general_clock_out_1 == $past(synthesizer_zero_div_b, 3);
   endproperty
   a_gen1: assert property (p_gen1) else $error("gen out 1 source");
   property p_fast0;
      fast_clock_out_0_oe |->
         fast_clock_out_0 == $past(synthesizer_one_div_a, 3);
   endproperty
   a_fast0: assert property (p_fast0) else $error("fast out 0 src");
   // pair flag must have held a cycle; outputs and flag both lag the register by one
   property p_leg0;
      pair0_differential_ff && $past(pair0_differential_ff)
         && fast_clock_out_0_oe |-> fast_clock_out_1 != fast_clock_out_0;
   endproperty
   a_leg0: assert property (p_leg0) else $error("pair 0 legs");
   property p_en0;
      pair0_differential_ff && $past(pair0_differential_ff) |->
         fast_clock_out_1_oe == fast_clock_out_0_oe;
   endproperty
   a_en0: assert property (p_en0) else $error("pair 0 enable");
   property p_leg2;
      pair2_differential_ff && $past(pair2_differential_ff)
         && fast_clock_out_2_oe |-> fast_clock_out_3 != fast_clock_out_2;
   endproperty
   a_leg2: assert property (p_leg2) else $error("pair 2 legs");
   property p_en2;
      pair2_differential_ff && $past(pair2_differential_ff) |->
         fast_clock_out_3_oe == fast_clock_out_2_oe;
   endproperty
   a_en2: assert property (p_en2) else $error("pair 2 enable");
   property p_off3;
      !fast_clock_out_3_oe |-> !fast_clock_out_3;
   endproperty
   a_off3: assert property (p_off3) else $error("idle out 3 not low");
   property p_ar;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_ar: assert property (p_ar) else $error("read answer late");
   property p_bhold;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_bhold: assert property (p_bhold) else $error("write taken early");
endmodule // cor_monitor

bind cor_top cor_monitor mon_u (.*);

`default_nettype wire

// file: dv/testbench.sv
/*
 * testbench: register access and output routing tests of cor_top.
 * assumes the design and the monitor bind are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam logic [11:0] GEN = 12'h938;
   localparam logic [11:0] FMT = 12'h940;
   localparam logic [11:0] SEL = 12'h944;
   // pair-2 copy bit is cleared wherever output-3 enable is clear
   localparam logic [7:0] FMT_T [6] = '{8'h0f, 8'h5f, 8'h03, 8'ha5,
      8'hfa, 8'h2d};
   localparam logic [7:0] SEL_T [6] = '{8'h00, 8'h0c, 8'h08, 8'h04,
      8'h08, 8'h08};
   localparam logic [7:0] GEN_T [6] = '{8'h03, 8'h01, 8'h02, 8'h00,
      8'h03, 8'h02};
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic synthesizer_zero_div_a = 1'b0, synthesizer_zero_div_b = 1'b0;
   logic synthesizer_one_div_a = 1'b0, synthesizer_one_div_b = 1'b0;
   logic synthesizer_one_div_c = 1'b0, synthesizer_one_div_d = 1'b0;
   logic general_clock_out_0, general_clock_out_0_oe, general_clock_out_1;
   logic general_clock_out_1_oe, fast_clock_out_0, fast_clock_out_0_oe;
   logic fast_clock_out_1, fast_clock_out_1_oe, fast_clock_out_2;
   logic fast_clock_out_2_oe, fast_clock_out_3, fast_clock_out_3_oe;
   logic pair0_differential_ff, pair2_differential_ff;
   logic [7:0] cnt_ff = 8'h00;
   logic [5:0] hs0_ff = 6'h00, hs1_ff = 6'h00, hs2_ff = 6'h00;
   int errors = 0;
   int total_checks = 0;
   int cyc = 0;

   cor_top dut_u (.*);

   always #4 clk_sys = ~clk_sys;

   // divider stand-ins at distinct rates except zero B and one C, which share one, with a history of what the
   // design sampled so each route can be told apart
   always @(posedge clk_sys) begin
      cnt_ff <= cnt_ff + 8'h01;
      synthesizer_zero_div_a <= cnt_ff[3];
      synthesizer_zero_div_b <= cnt_ff[1];
      synthesizer_one_div_a <= cnt_ff[2];
      synthesizer_one_div_b <= cnt_ff[3] ^ cnt_ff[1];
      synthesizer_one_div_c <= cnt_ff[1];
      synthesizer_one_div_d <= cnt_ff[4];
      hs0_ff <= {synthesizer_zero_div_a, synthesizer_zero_div_b,
         synthesizer_one_div_a, synthesizer_one_div_b,
         synthesizer_one_div_c, synthesizer_one_div_d};
      hs1_ff <= hs0_ff;
      hs2_ff <= hs1_ff;
   end

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] st, output logic [1:0] r);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (!aw && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic ar;
      ar = 1'b0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (!ar && s_axi_arready) begin
            ar = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic wrchk(input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] st, input logic [1:0] er);
      logic [1:0] r;
      wr(a, d, st, r);
      check({30'h0000_0000, r}, {30'h0000_0000, er});
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [7:0] ed,
      input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check(d, {24'h00_0000, ed});
      check({30'h0000_0000, r}, {30'h0000_0000, er});
   endtask

   // program one setting, then compare every output pin for 32 cycles
   task automatic route(input logic [7:0] f, input logic [7:0] s,
      input logic [7:0] g);
      logic [1:0] r;
      logic [5:0] h;
      logic [13:0] got, exp;
      logic s2, e1, n1, e3, n3;
      wr(FMT, f, 4'h1, r);
      wr(SEL, s, 4'h1, r);
      wr(GEN, g, 4'h1, r);
      repeat (3) @(posedge clk_sys);
      repeat (32) begin
         @(negedge clk_sys);
         h = hs2_ff;
         s2 = s[2] ? h[3] : h[1];
         n1 = f[5] ? f[0] : f[1];
         e1 = f[5] ? ~h[3] : (f[4] ? h[3] : h[2]);
         n3 = f[7] ? f[2] : f[3];
         e3 = f[7] ? ~s2 : (f[6] ? s2 : (s[3] ? h[2] : h[0]));
         got = {general_clock_out_0_oe, general_clock_out_0,
            general_clock_out_1_oe, general_clock_out_1,
            fast_clock_out_0_oe, fast_clock_out_0, fast_clock_out_1_oe,
            fast_clock_out_1, fast_clock_out_2_oe, fast_clock_out_2,
            fast_clock_out_3_oe, fast_clock_out_3, pair0_differential_ff,
            pair2_differential_ff};
         exp = {g[0], g[0] & h[5], g[1], g[1] & h[4], f[0], f[0] & h[3],
            n1, n1 & e1, f[2], f[2] & s2, n3, n3 & e3, f[5], f[7]};
         check(32'(got), 32'(exp));
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rdchk(GEN, 8'h00, 2'b00);
      rdchk(FMT, 8'hf0, 2'b00);
      rdchk(SEL, 8'h00, 2'b00);
      $display("test reset values done");
      wrchk(GEN, 8'hff, 4'hf, 2'b00);
      rdchk(GEN, 8'h03, 2'b00);
      wrchk(SEL, 8'hff, 4'hf, 2'b00);
      rdchk(SEL, 8'h0c, 2'b00);
      wrchk(FMT, 8'h00, 4'h0, 2'b00);
      rdchk(FMT, 8'hf0, 2'b00);
      wrchk(12'h000, 8'hff, 4'hf, 2'b10);
      rdchk(12'h004, 8'h00, 2'b10);
      $display("test access kinds done");
      for (int i = 0; i < 6; i++) begin
         route(FMT_T[i], SEL_T[i], GEN_T[i]);
      end
      $display("test routing done");
      wrchk(GEN, 8'h03, 4'h1, 2'b00);
      rst <= 1'b1;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rdchk(GEN, 8'h00, 2'b00);
      rdchk(FMT, 8'hf0, 2'b00);
      $display("test second reset done");
      conclude();
   end
endmodule // testbench

`default_nettype wire
